// File: hw/mnxu_exec_unit.sv
`timescale 1ns/1ps

// Overview of operation
// - File multiply forms unsigned product of working register and addressed byte.
// - Full 16-bit product goes to high and low product registers.
// - File multiply leaves working register and memory operand untouched.
// - File multiply changes no status flag at all.
// - Zero product is not flagged; multiplies give no overflow or carry.
// - Access bit 0 selects the access bank, ignoring bank select register.
// - Access bit 1 forms address from bank select register and file address.
// - Negate forms two's complement of addressed byte and updates all five flags.
// - Negate writes its result back to the same memory location.
// - Literal multiply forms unsigned product of working register and literal.
module mnxu_exec_unit (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_word_i,
  input  wire logic [7:0]  working_register_i,
  input  wire logic [3:0]  bank_select_register_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [11:0]      mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [7:0]       mem_wdata_o,
  output logic [7:0]       product_high_register_o,
  output logic [7:0]       product_low_register_o,
  output logic             negative_flag_o,
  output logic             overflow_flag_o,
  output logic             carry_flag_o,
  output logic             digit_carry_flag_o,
  output logic             zero_flag_o
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    mnxu_pkg::mnxu_phase_e phase;
    mnxu_pkg::mnxu_op_e    op;
    logic [15:0]           instr;
    logic [7:0]            working_register;
    logic [7:0]            operand;
    logic [11:0]           addr;
    logic                  mem_rd;
    logic                  mem_wr;
    logic [7:0]            wdata;
    logic [7:0]            prod_hi;
    logic [7:0]            prod_lo;
    logic [4:0]            flags;
    logic                  busy;
    logic                  done;
  } mnxu_state_s;

  mnxu_state_s state_reg;
  mnxu_state_s state_next;

  function automatic logic [11:0] file_address(input logic [15:0] w, input logic [3:0] bank_select_register);
    logic [7:0] f;
    f = w[mnxu_pkg::FILE_MSB:0];
    if (w[mnxu_pkg::ACCESS_BIT]) begin
      file_address = {bank_select_register, f};
    end else if (f < mnxu_pkg::ACCESS_SPLIT) begin
      file_address = {mnxu_pkg::ACCESS_LO_BK, f};
    end else begin
      file_address = {mnxu_pkg::ACCESS_HI_BK, f};
    end
  endfunction : file_address

  logic       is_mul_file;
  logic       is_mul_lit;
  logic       is_neg_file;
  logic [7:0] neg_result;
  logic [4:0] neg_low_sum;
  logic [8:0] neg_sum;
  logic [15:0] product;

  assign is_mul_file = instr_word_i[mnxu_pkg::OPC7_MSB:mnxu_pkg::OPC7_LSB]
                       == mnxu_pkg::OPC_MUL_FILE_HI;
  assign is_mul_lit  = instr_word_i[mnxu_pkg::OPC7_MSB:mnxu_pkg::OPC8_LSB]
                       == mnxu_pkg::OPC_MUL_LIT_HI;
  assign is_neg_file = instr_word_i[mnxu_pkg::OPC7_MSB:mnxu_pkg::OPC7_LSB]
                       == mnxu_pkg::OPC_NEG_FILE_HI;

  // Invert then add one; carries come out of that very addition
  assign neg_sum     = {1'b0, ~state_reg.operand} + 9'h001;
  assign neg_low_sum = {1'b0, ~state_reg.operand[3:0]} + 5'h01;
  assign neg_result  = neg_sum[7:0];
  assign product     = state_reg.working_register * state_reg.operand;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    state_next        = state_reg;
    state_next.done   = 1'b0;
    state_next.mem_wr = 1'b0;
    state_next.mem_rd = 1'b0;
    unique case (state_reg.phase)
      mnxu_pkg::MNXU_IDLE: begin
        // Unknown opcodes are not ours; the decoder routes them elsewhere
        if (instr_valid_i && (is_mul_file || is_mul_lit || is_neg_file)) begin
          state_next.phase = mnxu_pkg::MNXU_Q1_DECODE;
          state_next.busy  = 1'b1;
          state_next.instr = instr_word_i;
          state_next.working_register  = working_register_i;
          state_next.addr  = file_address(instr_word_i, bank_select_register_i);
          if (is_mul_lit) begin
            state_next.op = mnxu_pkg::MNXU_OP_MUL_LIT;
          end else if (is_mul_file) begin
            state_next.op = mnxu_pkg::MNXU_OP_MUL_FILE;
          end else begin
            state_next.op = mnxu_pkg::MNXU_OP_NEG_FILE;
          end
        end
      end
      mnxu_pkg::MNXU_Q1_DECODE: begin
        state_next.phase  = mnxu_pkg::MNXU_Q2_READ;
        state_next.mem_rd = (state_reg.op != mnxu_pkg::MNXU_OP_MUL_LIT);
      end
      mnxu_pkg::MNXU_Q2_READ: begin
        state_next.phase = mnxu_pkg::MNXU_Q3_PROCESS;
        if (state_reg.op == mnxu_pkg::MNXU_OP_MUL_LIT) begin
          state_next.operand = state_reg.instr[mnxu_pkg::FILE_MSB:0];
        end else begin
          state_next.operand = mem_rdata_i;
        end
      end
      mnxu_pkg::MNXU_Q3_PROCESS: begin
        state_next.phase = mnxu_pkg::MNXU_Q4_WRITE;
        state_next.done  = 1'b1;
        if (state_reg.op == mnxu_pkg::MNXU_OP_NEG_FILE) begin
          state_next.mem_wr = 1'b1;
          state_next.wdata  = neg_result;
          state_next.flags[mnxu_pkg::FLG_N]  = neg_result[7];
          state_next.flags[mnxu_pkg::FLG_OV] = (state_reg.operand == 8'h80);
          state_next.flags[mnxu_pkg::FLG_C]  = neg_sum[8];
          state_next.flags[mnxu_pkg::FLG_DC] = neg_low_sum[4];
          state_next.flags[mnxu_pkg::FLG_Z]  = (neg_result == 8'h00);
        end else begin
          // Flags untouched, memory untouched
          state_next.prod_hi = product[15:8];
          state_next.prod_lo = product[7:0];
        end
      end
      mnxu_pkg::MNXU_Q4_WRITE: begin
        state_next.phase = mnxu_pkg::MNXU_IDLE;
        state_next.busy  = 1'b0;
      end
      default: begin
        state_next.phase = mnxu_pkg::MNXU_IDLE;
        state_next.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg         <= '0;
      state_reg.phase   <= mnxu_pkg::MNXU_IDLE;
      state_reg.prod_hi <= mnxu_pkg::PROD_RST;
      state_reg.prod_lo <= mnxu_pkg::PROD_RST;
      state_reg.flags   <= mnxu_pkg::FLAGS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign busy_o                  = state_reg.busy;
  assign done_o                  = state_reg.done;
  assign mem_addr_o              = state_reg.addr;
  assign mem_rd_o                = state_reg.mem_rd;
  assign mem_wr_o                = state_reg.mem_wr;
  assign mem_wdata_o             = state_reg.wdata;
  assign product_high_register_o = state_reg.prod_hi;
  assign product_low_register_o  = state_reg.prod_lo;
  assign negative_flag_o         = state_reg.flags[mnxu_pkg::FLG_N];
  assign overflow_flag_o         = state_reg.flags[mnxu_pkg::FLG_OV];
  assign carry_flag_o            = state_reg.flags[mnxu_pkg::FLG_C];
  assign digit_carry_flag_o      = state_reg.flags[mnxu_pkg::FLG_DC];
  assign zero_flag_o             = state_reg.flags[mnxu_pkg::FLG_Z];

  // ***************************************************************
  // Assertions
  // ***************************************************************
  logic is_mul_q3;
  assign is_mul_q3 = (state_reg.phase == mnxu_pkg::MNXU_Q3_PROCESS)
                     && (state_reg.op != mnxu_pkg::MNXU_OP_NEG_FILE);

  sequence q1_s;
    state_reg.phase == mnxu_pkg::MNXU_Q1_DECODE;
  endsequence
  sequence q2_to_q4_s;
    (state_reg.phase == mnxu_pkg::MNXU_Q2_READ) ##1
    (state_reg.phase == mnxu_pkg::MNXU_Q3_PROCESS) ##1
    (state_reg.phase == mnxu_pkg::MNXU_Q4_WRITE && done_o);
  endsequence

  phase_order_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    q1_s |=> q2_to_q4_s)
    else $error("four phases not in order");

  file_product_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_Q2_READ && state_reg.op == mnxu_pkg::MNXU_OP_MUL_FILE)
    |-> ##2 ({product_high_register_o, product_low_register_o}
             == $past(state_reg.working_register, 2) * $past(mem_rdata_i, 2)))
    else $error("file multiply product wrong");

  product_split_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    is_mul_q3 |=> (product_high_register_o == $past(product[15:8])
                   && product_low_register_o == $past(product[7:0])))
    else $error("product bytes misplaced");

  lit_product_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_Q1_DECODE && state_reg.op == mnxu_pkg::MNXU_OP_MUL_LIT)
    |-> ##3 ({product_high_register_o, product_low_register_o}
             == $past(state_reg.working_register, 3) * $past(state_reg.instr[7:0], 3)))
    else $error("literal multiply product wrong");

  mul_no_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    is_mul_q3 |=> !mem_wr_o)
    else $error("multiply wrote data memory");

  mul_flags_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    is_mul_q3 |=> $stable(state_reg.flags))
    else $error("multiply changed a flag");

  mul_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (is_mul_q3 && product == 16'h0000 && !zero_flag_o) |=> !zero_flag_o)
    else $error("zero product was flagged");

  access_bank_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_Q2_READ && !state_reg.instr[mnxu_pkg::ACCESS_BIT])
    |-> (mem_addr_o[11:8] == ((state_reg.instr[7:0] < mnxu_pkg::ACCESS_SPLIT)
         ? mnxu_pkg::ACCESS_LO_BK : mnxu_pkg::ACCESS_HI_BK)))
    else $error("access bank address wrong");

  banked_addr_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_IDLE && instr_valid_i && !is_mul_lit
     && (is_mul_file || is_neg_file) && instr_word_i[mnxu_pkg::ACCESS_BIT])
    |=> (mem_addr_o == {$past(bank_select_register_i), $past(instr_word_i[7:0])}))
    else $error("banked address wrong");

  negate_value_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_Q2_READ && state_reg.op == mnxu_pkg::MNXU_OP_NEG_FILE)
    |-> ##2 (mem_wdata_o == 8'(8'h00 - $past(mem_rdata_i, 2))
             && zero_flag_o == (mem_wdata_o == 8'h00)
             && carry_flag_o == ($past(mem_rdata_i, 2) == 8'h00)))
    else $error("negate result or flags wrong");

  negate_dest_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_reg.phase == mnxu_pkg::MNXU_Q2_READ && state_reg.op == mnxu_pkg::MNXU_OP_NEG_FILE)
    |-> ##2 (mem_wr_o && mem_addr_o == $past(mem_addr_o, 2)))
    else $error("negate written to wrong place");

endmodule : mnxu_exec_unit

// File: hw/mnxu_pkg.sv
package mnxu_pkg;

  // ***************************************************************
  // Opcode patterns
  // ***************************************************************
  localparam logic [6:0] OPC_MUL_FILE_HI = 7'h01;  // 0000 001a
  localparam logic [7:0] OPC_MUL_LIT_HI  = 8'h0D;  // 0000 1101
  localparam logic [6:0] OPC_NEG_FILE_HI = 7'h36;  // 0110 110a

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int OPC7_MSB   = 15;
  localparam int OPC7_LSB   = 9;
  localparam int OPC8_LSB   = 8;
  localparam int ACCESS_BIT = 8;
  localparam int FILE_MSB   = 7;

  // ***************************************************************
  // Data memory layout
  // ***************************************************************
  localparam int          ADDR_W       = 12;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BK = 4'hF;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0]  PROD_RST  = 8'h00;
  localparam logic [4:0]  FLAGS_RST = 5'h00;

  // Flag vector positions
  localparam int FLG_N  = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_C  = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 0;

  typedef enum logic [1:0] {
    MNXU_OP_MUL_FILE,
    MNXU_OP_MUL_LIT,
    MNXU_OP_NEG_FILE
  } mnxu_op_e;

  typedef enum logic [2:0] {
    MNXU_IDLE,
    MNXU_Q1_DECODE,
    MNXU_Q2_READ,
    MNXU_Q3_PROCESS,
    MNXU_Q4_WRITE
  } mnxu_phase_e;

endpackage : mnxu_pkg

// File: verif/tb_mnxu_exec_unit.sv
`timescale 1ns/1ps

module tb_mnxu_exec_unit;
  // ***************************************************************
  // Stimulus and observed signals
  // ***************************************************************
  logic        ref_clk_i              = 1'b0;
  logic        resetn_i               = 1'b0;
  logic        instr_valid_i          = 1'b0;
  logic [15:0] instr_word_i           = 16'h0000;
  logic [7:0]  working_register_i     = 8'h00;
  logic [3:0]  bank_select_register_i = 4'h0;
  logic [7:0]  mem_rdata_i            = 8'h00;
  logic        busy_o;
  logic        done_o;
  logic [11:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  product_high_register_o;
  logic [7:0]  product_low_register_o;
  logic        negative_flag_o;
  logic        overflow_flag_o;
  logic        carry_flag_o;
  logic        digit_carry_flag_o;
  logic        zero_flag_o;
  int          n_fail      = 0;
  int          comparisons = 0;
  logic [4:0]  exp_flg     = 5'h00;
  logic [15:0] exp_prod    = 16'h0000;
  logic [15:0] bad_ops [3] = '{16'h6E20, 16'h0E55, 16'h0420};

  always #2.5 ref_clk_i = ~ref_clk_i;

  mnxu_exec_unit u_dut (
    .ref_clk_i              (ref_clk_i),
    .resetn_i               (resetn_i),
    .instr_valid_i          (instr_valid_i),
    .instr_word_i           (instr_word_i),
    .working_register_i     (working_register_i),
    .bank_select_register_i (bank_select_register_i),
    .mem_rdata_i            (mem_rdata_i),
    .busy_o                 (busy_o),
    .done_o                 (done_o),
    .mem_addr_o             (mem_addr_o),
    .mem_rd_o               (mem_rd_o),
    .mem_wr_o               (mem_wr_o),
    .mem_wdata_o            (mem_wdata_o),
    .product_high_register_o(product_high_register_o),
    .product_low_register_o (product_low_register_o),
    .negative_flag_o        (negative_flag_o),
    .overflow_flag_o        (overflow_flag_o),
    .carry_flag_o           (carry_flag_o),
    .digit_carry_flag_o     (digit_carry_flag_o),
    .zero_flag_o            (zero_flag_o)
  );

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // One instruction; optionally a second request is pushed while busy
  task automatic run_op(input logic [15:0] word, input logic [7:0] w, input logic [3:0] bank_select_register,
                        input logic [7:0] rd, input logic [11:0] addr, input bit intrude);
    logic       is_neg;
    logic       is_mem;
    logic [7:0] res;
    is_neg = (word[15:9] == mnxu_pkg::OPC_NEG_FILE_HI);
    is_mem = is_neg || (word[15:9] == mnxu_pkg::OPC_MUL_FILE_HI);
    res    = ~rd + 8'h01;
    if (is_neg) begin
      exp_flg = {res[7], rd == 8'h80, rd == 8'h00, rd[3:0] == 4'h0, res == 8'h00};
    end else begin
      exp_prod = {8'h00, w} * {8'h00, (is_mem ? rd : word[7:0])};
    end
    @(posedge ref_clk_i);
    instr_valid_i          <= 1'b1;
    instr_word_i           <= word;
    working_register_i     <= w;
    bank_select_register_i <= bank_select_register;
    mem_rdata_i            <= rd;
    @(posedge ref_clk_i);
    instr_valid_i          <= 1'b0;
    working_register_i     <= ~w;
    bank_select_register_i <= ~bank_select_register;
    for (int c = 1; c <= 4; c++) begin
      #1;
      check("busy", busy_o, 16'h0001);
      if (is_mem) check("addr", mem_addr_o, addr);
      check("mem_rd", mem_rd_o, (c == 2 && is_mem));
      check("done", done_o, (c == 4));
      check("mem_wr", mem_wr_o, (c == 4 && is_neg));
      if (c == 4 && is_neg) check("wdata", mem_wdata_o, res);
      @(posedge ref_clk_i);
      if (intrude) begin
        instr_valid_i <= (c < 3);
        instr_word_i  <= 16'h0DFF;
      end
      if (c == 2) mem_rdata_i <= ~rd;
    end
    #1;
    check("idle", {busy_o, done_o}, 16'h0000);
    check("product", {product_high_register_o, product_low_register_o}, exp_prod);
    check("flags", {negative_flag_o, overflow_flag_o, carry_flag_o, digit_carry_flag_o,
                    zero_flag_o}, exp_flg);
  endtask : run_op

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    run_op(16'h0DC4, 8'hE2, 4'h0, 8'h5A, 12'h000, 1'b0);
    run_op(16'h0220, 8'hC4, 4'h7, 8'hB5, 12'h020, 1'b0);
    run_op(16'h025F, 8'h10, 4'h7, 8'h11, 12'h05F, 1'b0);
    run_op(16'h0260, 8'h03, 4'h7, 8'h40, 12'hF60, 1'b0);
    run_op(16'h0312, 8'hFF, 4'h5, 8'hFF, 12'h512, 1'b1);
    run_op(16'h6D44, 8'h00, 4'h3, 8'h3A, 12'h344, 1'b0);
    run_op(16'h6C10, 8'h00, 4'h3, 8'h00, 12'h010, 1'b0);
    run_op(16'h6CF0, 8'h00, 4'h9, 8'h80, 12'hFF0, 1'b1);
    run_op(16'h0D55, 8'h00, 4'h0, 8'h00, 12'h000, 1'b0);
    run_op(16'h6C21, 8'h00, 4'h0, 8'hF0, 12'h021, 1'b0);
    run_op(16'h0321, 8'h02, 4'hA, 8'h00, 12'hA21, 1'b0);
    // Neighbouring opcodes must not start a cycle
    foreach (bad_ops[i]) begin
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b1;
      instr_word_i  <= bad_ops[i];
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check("ignored", busy_o, 16'h0000);
    end
    end_sim();
  end

  // Whole run is under a hundred cycles; this bound is generous
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule : tb_mnxu_exec_unit
